/* pkg/rop_pkg.sv */
// Constants for the interrupt-return and option-load decode block.
// Assumes a core with a 14-bit instruction word and 8-bit data path.
package rop_pkg;
   // ==========================================================
   // Widths
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int PC_W   = 13;
   // ==========================================================
   // Encodings
   localparam logic [13:0] OP_RET_IRQ  = 14'h0009;
   localparam logic [13:0] OP_OPT_LOAD = 14'h0062;
   // ==========================================================
   // Field positions, phase codes, reset values and cycle counts
   localparam int          GIE_BIT      = 7;
   localparam logic [1:0]  QPH_RST      = 2'h0;
   localparam logic [1:0]  QPH_Q1       = 2'h0;
   localparam logic [1:0]  QPH_Q3       = 2'h2;
   localparam logic [1:0]  QPH_Q4       = 2'h3;
   localparam logic [7:0]  OPTION_RST   = 8'hFF;
   localparam int          RET_CYCLES   = 2;
   localparam logic [12:0] PC_RST       = 13'h0000;
   localparam logic [7:0]  INTERRUPT_CONTROL_REG_RST   = 8'h00;
   localparam int          FLUSH_CLKS   = 4;
endpackage

/* rtl/rop_decode.sv */
// Decode and execute for the interrupt return and option-load ops.
// Assumes fetch presents the instruction word for a whole 4-Q cycle,
// the stack pops on a one-cycle pulse and W is always valid.
`timescale 1ns/1ns
module rop_decode (
   input  wire logic                      clk_i,
   input  wire logic                      nrst_i,
   input  wire logic [rop_pkg::INSN_W-1:0] insn_i,
   input  wire logic [rop_pkg::DATA_W-1:0] w_reg_i,
   input  wire logic [rop_pkg::PC_W-1:0]   stack_top_entry_i,
   input  wire logic                      opt_wr_i,
   input  wire logic [rop_pkg::DATA_W-1:0] opt_wdata_i,
   input  wire logic                      interrupt_control_reg_wr_i,
   input  wire logic [rop_pkg::DATA_W-1:0] interrupt_control_reg_wdata_i,
   output logic [1:0]                     qph_o,
   output logic                           stack_pop_o,
   output logic                           pc_load_o,
   output logic [rop_pkg::PC_W-1:0]        program_counter_o,
   output logic                           fetch_flush_o,
   output logic [rop_pkg::DATA_W-1:0]      interrupt_control_reg_o,
   output logic [rop_pkg::DATA_W-1:0]      option_reg_o,
   output logic                           status_we_o
);
   import rop_pkg::*;

   typedef enum logic {RP_EXEC, RP_IDLE2} rop_state_e;

   // ==========================================================
   // Phase timing
   logic [1:0] qph;
   logic       q4;
   rop_qphase u_qph (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .qph_o  (qph),
      .q4_o   (q4)
   );
   assign qph_o = qph;

   // ==========================================================
   // Decode
   rop_state_e state_ff;
   rop_state_e nxt_state;
   logic [PC_W-1:0]   pc_ff;
   logic [DATA_W-1:0] interrupt_control_reg_ff;
   logic [DATA_W-1:0] option_ff;
   logic              pop_ff;

   wire in_exec   = (state_ff == RP_EXEC);
   wire is_ret    = in_exec && (insn_i == OP_RET_IRQ);
   wire is_optld  = in_exec && (insn_i == OP_OPT_LOAD);
   wire gie_set   = is_ret && (qph == QPH_Q3);
   wire pop_now   = is_ret && q4;
   wire opt_now   = is_optld && q4;

   // Second cycle of the return is a forced no-op; fetched word is
   // discarded so execution resumes at the restored address.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         RP_EXEC:  if (pop_now) nxt_state = RP_IDLE2;
         RP_IDLE2: if (q4) nxt_state = RP_EXEC;
         default:  nxt_state = RP_EXEC;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= RP_EXEC;
         pop_ff   <= 1'b0;
         pc_ff    <= PC_RST;
      end else begin
         state_ff <= nxt_state;
         pop_ff   <= pop_now;
         if (pop_now) begin
            pc_ff <= stack_top_entry_i;
         end
      end
   end

   // Hardware set wins over a software write in the same cycle.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         interrupt_control_reg_ff <= INTERRUPT_CONTROL_REG_RST;
      end else begin
         if (interrupt_control_reg_wr_i) begin
            interrupt_control_reg_ff <= interrupt_control_reg_wdata_i;
         end
         if (gie_set) begin
            interrupt_control_reg_ff[GIE_BIT] <= 1'b1;
         end
      end
   end

   // Option register stays a normal file register; the legacy op is
   // kept only for old code, which should use the file write instead.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         option_ff <= OPTION_RST;
      end else if (opt_now) begin
         option_ff <= w_reg_i;
      end else if (opt_wr_i) begin
         option_ff <= opt_wdata_i;
      end
   end

   // ==========================================================
   // Second-cycle length tracker
   // Counts clocks spent in the forced no-op so the checks below can
   // catch a stall that would swallow the next fetched word.
   localparam logic [2:0] FLUSH_LAST = 3'(FLUSH_CLKS - 1);
   logic [2:0] flush_cnt_ff;
   wire  [2:0] nxt_flush_cnt = (state_ff == RP_IDLE2) ?
                               flush_cnt_ff + 3'h1 : 3'h0;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flush_cnt_ff <= 3'h0;
      end else begin
         flush_cnt_ff <= nxt_flush_cnt;
      end
   end

   // ==========================================================
   // Outputs
   assign stack_pop_o             = pop_now;
   assign pc_load_o               = pop_ff;
   assign program_counter_o       = pc_ff;
   assign fetch_flush_o           = (state_ff == RP_IDLE2);
   assign interrupt_control_reg_o = interrupt_control_reg_ff;
   assign option_reg_o            = option_ff;
   assign status_we_o             = 1'b0;

   // ==========================================================
   // Checks
   a_ret_pops_pc: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      pop_now |=> (pc_load_o && program_counter_o == $past(stack_top_entry_i)))
      else $error("return did not load popped entry");
   a_pop_in_q4: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      stack_pop_o |-> qph == QPH_Q4)
      else $error("stack popped outside Q4");
   a_pop_one_clk: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      stack_pop_o |=> !stack_pop_o)
      else $error("stack pop longer than one clock");
   a_pc_load_pulse: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      pc_load_o |=> !pc_load_o)
      else $error("program counter load longer than one clock");
   a_pc_holds: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !stack_pop_o |=> $stable(program_counter_o))
      else $error("restored address changed without a pop");
   a_ret_sets_gie: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      gie_set |=> interrupt_control_reg_o[GIE_BIT])
      else $error("global enable not set on return");
   a_gie_at_pop: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      pop_now |-> interrupt_control_reg_o[GIE_BIT])
      else $error("global enable low when stack pops");
   a_ret_two_cyc: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      pop_now |=> fetch_flush_o [*4] ##1 !fetch_flush_o)
      else $error("return second cycle wrong length");
   a_ret_no_repop: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      fetch_flush_o |-> !stack_pop_o)
      else $error("pop during idle cycle");
   a_flush_len: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (fetch_flush_o && flush_cnt_ff == FLUSH_LAST) |=> !fetch_flush_o)
      else $error("idle cycle overran one instruction cycle");
   a_flush_max: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      fetch_flush_o |-> flush_cnt_ff <= FLUSH_LAST)
      else $error("idle cycle counter out of range");
   a_flush_from_ret: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(fetch_flush_o) |-> $past(stack_pop_o))
      else $error("idle cycle entered without a pop");
   a_flush_q1_start: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(fetch_flush_o) |-> qph == QPH_Q1)
      else $error("idle cycle not aligned to Q1");
   a_flush_no_gie: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (fetch_flush_o && !interrupt_control_reg_wr_i) |=> $stable(interrupt_control_reg_o))
      else $error("interrupt control changed in idle cycle");
   a_flush_no_opt: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (fetch_flush_o && !opt_wr_i) |=> $stable(option_reg_o))
      else $error("option register changed in idle cycle");
   a_qph_steps: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      1'b1 |=> qph_o == 2'($past(qph_o) + 2'h1))
      else $error("Q phase did not advance by one");
   a_opt_load_w: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      opt_now |=> option_reg_o == $past(w_reg_i))
      else $error("option register not loaded from W");
   a_opt_one_cyc: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      opt_now |=> !fetch_flush_o)
      else $error("option load stalled fetch");
   a_opt_no_branch: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      is_optld |-> (!stack_pop_o && !pc_load_o))
      else $error("option load touched the stack");
   a_opt_keeps_gie: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (opt_now && !interrupt_control_reg_wr_i) |=> $stable(interrupt_control_reg_o))
      else $error("option load changed interrupt control");
   a_no_status_wr: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (is_ret || is_optld) |-> !status_we_o)
      else $error("status flags written");
   a_file_wr_opt: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (opt_wr_i && !opt_now) |=> option_reg_o == $past(opt_wdata_i))
      else $error("option file write lost");
endmodule

/* rtl/rop_qphase.sv */
// Four-phase instruction cycle generator.
// Assumes one core clock edge per Q phase.
`timescale 1ns/1ns
module rop_qphase (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   output logic [1:0]      qph_o,
   output logic            q4_o
);
   import rop_pkg::*;

   logic [1:0] qph_ff;
   wire  [1:0] nxt_qph = qph_ff + 2'h1;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         qph_ff <= QPH_RST;
      end else begin
         qph_ff <= nxt_qph;
      end
   end

   assign qph_o = qph_ff;
   assign q4_o  = (qph_ff == QPH_Q4);
endmodule

/* tb/irq_return_and_option_load_ops_tb_top.sv */
// Bench for the return and option-load decode block.
// Assumes the fetch model feeds words and the stack top; the bench drives the rest.
`timescale 1ns/1ns
module irq_return_and_option_load_ops_tb_top;
   import rop_pkg::*;
   logic        clk_i = 0, nrst_i = 0, ow = 0, iw = 0, pop, pl, fl, swe;
   logic [13:0] req = 0, insn;
   logic [13:0] tbl [3] = '{OP_RET_IRQ, OP_OPT_LOAD, 14'h0000};
   logic [7:0]  w = 0, od = 0, id = 0, ic, opt, m_ic = 0, m_opt = 8'hFF;
   logic [12:0] stack_top_entry, pc, m_pc = 0;
   logic [1:0]  qph;
   logic [28:0] q[$], e;
   int          error_cnt = 0, cmp_count = 0, fc = 0;
   rop_fetch_model u_fetch (.clk_i(clk_i), .qph_i(qph), .pop_i(pop),
      .req_i(req), .insn_o(insn), .tos_o(stack_top_entry));
   rop_decode u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .insn_i(insn),
      .w_reg_i(w), .stack_top_entry_i(stack_top_entry), .opt_wr_i(ow),
      .opt_wdata_i(od), .interrupt_control_reg_wr_i(iw), .interrupt_control_reg_wdata_i(id),
      .qph_o(qph), .stack_pop_o(pop), .pc_load_o(pl),
      .program_counter_o(pc), .fetch_flush_o(fl),
      .interrupt_control_reg_o(ic), .option_reg_o(opt), .status_we_o(swe));
   // ==============================
   task automatic ck(input logic [28:0] s, input logic [28:0] x);
      cmp_count++;
      if (s !== x) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // File writes land at the end of Q1 so the instruction's effect wins
   task automatic op(input logic [13:0] i, input int fw);
      do @(negedge clk_i); while (qph !== 2'h2);
      req = i;
      q.push_back({m_pc, m_ic, m_opt});
      repeat (2) @(negedge clk_i);
      w = 8'($urandom);
      od = 8'($urandom);
      id = 8'($urandom);
      ow = (fw == 1);
      iw = (fw == 2);
      if (ow) m_opt = od;
      if (iw) m_ic = id;
      if (i == OP_OPT_LOAD) m_opt = w;
      if (i == OP_RET_IRQ) begin
         m_pc = stack_top_entry;
         m_ic[GIE_BIT] = 1'b1;
      end
      @(negedge clk_i);
      ow = 0;
      iw = 0;
      if (i == OP_RET_IRQ) repeat (4) @(negedge clk_i);
   endtask
   // ==============================
   always @(negedge clk_i) begin
      if (pl === 1'b1) ck(fl, 1'b1);
      if (pop === 1'b1) ck(qph, QPH_Q4);
      if (fl === 1'b1) fc++;
      else if (fc != 0) begin
         ck(29'(fc), 29'(FLUSH_CLKS));
         fc = 0;
      end
      if (qph === 2'h0 && fl === 1'b0 && q.size() > 0) begin
         e = q.pop_front();
         ck(pc, e[28:16]);
         ck(ic, e[15:8]);
         ck(opt, e[7:0]);
         ck(swe, 1'b0);
      end
   end
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      #20000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      void'($urandom(60083));
      repeat (8) @(negedge clk_i);
      nrst_i = 1;
      for (int k = 0; k < 42; k++) begin
         op(k < 2 ? OP_RET_IRQ : (k < 4 ? OP_OPT_LOAD : tbl[$urandom % 3]),
            $urandom % 3);
      end
      q.push_back({m_pc, m_ic, m_opt});
      wait (q.size() == 0);
      $display("test mixed_ops done");
      end_of_test();
   end
endmodule

/* tb/rop_fetch_model.sv */
// Fetch stage model: one word per four-phase cycle, plus stack top.
// Assumes the bench sets req_i before the Q1 falling edge, where it is sampled.
`timescale 1ns/1ns
module rop_fetch_model (
   input  wire logic        clk_i,
   input  wire logic [1:0]  qph_i,
   input  wire logic        pop_i,
   input  wire logic [13:0] req_i,
   output logic      [13:0] insn_o,
   output logic      [12:0] tos_o
);
   import rop_pkg::*;
   initial begin
      insn_o = 14'h0000;
      tos_o  = 13'h0ABC;
   end
   // ==============================
   // Word held for a whole cycle; slot after a return is a no-op
   always @(negedge clk_i) begin
      if (qph_i == QPH_Q1) begin
         insn_o <= (insn_o == OP_RET_IRQ) ? 14'h0000 : req_i;
      end
   end
   // Popped entry is gone, so a fresh value replaces it
   always @(posedge clk_i) begin
      if (pop_i) begin
         tos_o <= 13'($urandom);
      end
   end
endmodule
